// ---- rtl/spm_mem.v ----
// Parameter memory array with one write port and a registered read port
`timescale 1ns/100ps
`default_nettype none
`include "spm_write_port_regs.vh"
module param_mem_array (
  input wire i_mclk,
  input wire i_wr_en,
  input wire [`PMEM_ADDR_W-1:0] i_wr_addr,
  input wire [`PMEM_DATA_W-1:0] i_wr_data,
  input wire i_rd_en,
  input wire [`PMEM_ADDR_W-1:0] i_rd_addr,
  output reg [`PMEM_DATA_W-1:0] o_rd_data
);
  reg [`PMEM_DATA_W-1:0] mem [0:(1<<`PMEM_ADDR_W)-1];

  always @(posedge i_mclk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
    if (i_rd_en) begin
      o_rd_data <= mem[i_rd_addr];
    end
  end
endmodule
`default_nettype wire

// ---- rtl/spm_write_port_regs.vh ----
// Register map, field positions and sizes of the parameter memory write port
`ifndef PMEM_WRITE_PORT_REGS_VH
`define PMEM_WRITE_PORT_REGS_VH

`define PMEM_ADDR_W 8
`define PMEM_DATA_W 32
`define PMEM_SPR_W 3
`define PMEM_WORD_W 4

`define REG_CTRL 12'h000
`define REG_FIELD_MASK 12'h004
`define REG_STATUS 12'h008
`define PMEM_WINDOW_BASE 12'h400
`define PMEM_WINDOW_SEL 11:10
`define PMEM_WINDOW_TAG 2'b01
`define PMEM_WINDOW_IDX 9:2

`define CTRL_LEGACY_BIT 0
`define CTRL_NOFETCH_LSB 8
`define CTRL_NOFETCH_MSB 15
`define CTRL_RESET 32'h0000_0000
`define FIELD_MASK_RESET 16'h000f
`define CNT_W 16

`endif

// ---- rtl/spreader_param_write_port.v ----
// Write arbitration into spreader parameter memory with APB register slave
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "spm_write_port_regs.vh"
module spreader_param_write_port (
  input wire i_mclk,
  input wire i_rst,
  // APB slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire o_pready,
  output reg [31:0] o_prdata,
  output wire o_pslverr,
  // Header fetch write port
  input wire i_fetch_wr,
  input wire i_fetch_bank,
  input wire [`PMEM_SPR_W-1:0] i_fetch_spreader,
  input wire [`PMEM_WORD_W-1:0] i_fetch_word,
  input wire [`PMEM_DATA_W-1:0] i_fetch_data,
  output reg o_fetch_lost,
  output reg o_fetch_refused,
  // Datapath read port
  input wire i_dp_rd,
  input wire i_dp_bank,
  input wire [`PMEM_SPR_W-1:0] i_dp_spreader,
  input wire [`PMEM_WORD_W-1:0] i_dp_word,
  output wire [`PMEM_DATA_W-1:0] o_dp_rdata
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function is_window;
    input [11:0] addr;
    begin
      is_window = (addr[`PMEM_WINDOW_SEL] == `PMEM_WINDOW_TAG);
    end
  endfunction

  function is_mapped;
    input [11:0] addr;
    begin
      is_mapped = is_window(addr) || addr == `REG_CTRL ||
                  addr == `REG_FIELD_MASK || addr == `REG_STATUS;
    end
  endfunction

  reg [31:0] ctrl_reg;
  reg [15:0] field_mask_reg;
  reg [`CNT_W-1:0] lost_cnt_reg;
  reg [`CNT_W-1:0] defer_cnt_reg;

  wire legacy_mode = ctrl_reg[`CTRL_LEGACY_BIT];
  wire [7:0] nofetch_mask = ctrl_reg[`CTRL_NOFETCH_MSB:`CTRL_NOFETCH_LSB];

  wire access = i_psel && i_penable;
  wire sw_win_wr = access && i_pwrite && is_window(i_paddr);

  // ----------------------------------------------------------------
  // Fetch write qualification
  // ----------------------------------------------------------------
  // Non-fetching spreaders take no header writes
  wire fetch_spr_ok = !nofetch_mask[i_fetch_spreader];
  // Only per-period header words may be written by the fetch
  wire fetch_word_ok = field_mask_reg[i_fetch_word];
  wire fetch_valid = i_fetch_wr && fetch_spr_ok && fetch_word_ok;

  wire collide = fetch_valid && sw_win_wr;

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  // Legacy: software wins outright and the fetch write vanishes
  wire fetch_dropped = collide && legacy_mode;
  // Corrected: software write waits in its access phase for every cycle a fetch write collides
  wire sw_stall = collide && !legacy_mode;
  wire sw_commit = sw_win_wr && !sw_stall;
  wire fetch_commit = fetch_valid && !fetch_dropped;

  assign o_pready = !sw_stall;
  assign o_pslverr = access && !is_mapped(i_paddr);

  reg wr_en;
  reg [`PMEM_ADDR_W-1:0] wr_addr;
  reg [`PMEM_DATA_W-1:0] wr_data;

  always @* begin
    wr_en = 1'b0;
    wr_addr = {`PMEM_ADDR_W{1'b0}};
    wr_data = {`PMEM_DATA_W{1'b0}};
    if (fetch_commit) begin
      // Bank by period parity so a lost write leaves period N-2 values
      wr_en = 1'b1;
      wr_addr = {i_fetch_bank, i_fetch_spreader, i_fetch_word};
      wr_data = i_fetch_data;
    end else if (sw_commit) begin
      wr_en = 1'b1;
      wr_addr = i_paddr[`PMEM_WINDOW_IDX];
      wr_data = i_pwdata;
    end
  end

  param_mem_array u_mem (
    .i_mclk(i_mclk),
    .i_wr_en(wr_en),
    .i_wr_addr(wr_addr),
    .i_wr_data(wr_data),
    .i_rd_en(i_dp_rd),
    .i_rd_addr({i_dp_bank, i_dp_spreader, i_dp_word}),
    .o_rd_data(o_dp_rdata)
  );

  // ----------------------------------------------------------------
  // Control registers and event counters
  // ----------------------------------------------------------------
  wire reg_wr = access && i_pwrite && o_pready;
  wire status_clr = reg_wr && i_paddr == `REG_STATUS;

  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_reg <= `CTRL_RESET;
      field_mask_reg <= `FIELD_MASK_RESET;
      lost_cnt_reg <= {`CNT_W{1'b0}};
      defer_cnt_reg <= {`CNT_W{1'b0}};
      o_fetch_lost <= 1'b0;
      o_fetch_refused <= 1'b0;
    end else begin
      o_fetch_lost <= fetch_dropped;
      o_fetch_refused <= i_fetch_wr && !(fetch_spr_ok && fetch_word_ok);
      if (reg_wr && i_paddr == `REG_CTRL) begin
        ctrl_reg <= i_pwdata;
      end
      if (reg_wr && i_paddr == `REG_FIELD_MASK) begin
        field_mask_reg <= i_pwdata[15:0];
      end
      // Event increments win over a clear in the same cycle
      if (fetch_dropped) begin
        if (lost_cnt_reg != {`CNT_W{1'b1}}) begin
          lost_cnt_reg <= lost_cnt_reg + 1'b1;
        end
      end else if (status_clr) begin
        lost_cnt_reg <= {`CNT_W{1'b0}};
      end
      if (sw_stall) begin
        if (defer_cnt_reg != {`CNT_W{1'b1}}) begin
          defer_cnt_reg <= defer_cnt_reg + 1'b1;
        end
      end else if (status_clr) begin
        defer_cnt_reg <= {`CNT_W{1'b0}};
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data, loaded during the setup cycle
  // ----------------------------------------------------------------
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_prdata <= 32'h0000_0000;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      case (i_paddr)
        `REG_CTRL: o_prdata <= ctrl_reg;
        `REG_FIELD_MASK: o_prdata <= {16'h0000, field_mask_reg};
        `REG_STATUS: o_prdata <= {defer_cnt_reg, lost_cnt_reg};
        default: o_prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- testbench/fetch_model.sv ----
// Header fetch engine stand-in
`timescale 1ns/100ps
`default_nettype none
module fetch_model (
  input wire logic i_mclk,
  input wire logic i_go,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_data,
  output logic o_wr = 1'b0,
  output logic [7:0] o_addr = 8'h00,
  output logic [31:0] o_data = 32'h0
);
  always @(posedge i_mclk) begin
    o_wr <= i_go;
    o_addr <= i_go ? i_addr : ~o_addr;
    o_data <= i_go ? i_data : ~o_data;
  end
endmodule
`default_nettype wire

// ---- testbench/spw_asserts.sv ----
// Port checks for the parameter memory write port
`timescale 1ns/100ps
`default_nettype none
module spw_asserts (
  input wire logic i_mclk, i_rst, i_psel, i_penable, i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic i_fetch_wr, i_dp_rd, o_pready, o_pslverr,
  input wire logic o_fetch_lost, o_fetch_refused,
  input wire logic [31:0] o_dp_rdata
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // Read data is unknown until the first datapath read
  logic seen_rd = 1'b0;
  always @(posedge i_mclk) begin
    if (i_dp_rd) begin
      seen_rd <= 1'b1;
    end
  end
  sequence s_win;
    i_psel && i_penable && i_pwrite && i_paddr[11:10] == 2'b01;
  endsequence
  sequence s_clash;
    s_win ##0 i_fetch_wr && o_pready;
  endsequence
  property p_drop; s_clash |=> o_fetch_lost || o_fetch_refused; endproperty
  property p_stall; !o_pready |-> i_fetch_wr && i_psel; endproperty
  property p_lost; o_fetch_lost |-> $past(i_fetch_wr) && $past(i_psel);
  endproperty
  property p_ref; o_fetch_refused |-> $past(i_fetch_wr); endproperty
  property p_excl; !(o_fetch_lost && o_fetch_refused); endproperty
  property p_hold; seen_rd && !i_dp_rd |=> $stable(o_dp_rdata);
  endproperty
  property p_solo; i_fetch_wr && !i_psel |=> !o_fetch_lost; endproperty
  property p_win; s_win |-> !o_pslverr; endproperty
  a_drop: assert property (p_drop) else $error("fetch kept");
  a_stall: assert property (p_stall) else $error("bad stall");
  a_lost: assert property (p_lost) else $error("bad lost");
  a_ref: assert property (p_ref) else $error("bad refuse");
  a_excl: assert property (p_excl) else $error("both pulses");
  a_hold: assert property (p_hold) else $error("rdata moved");
  a_solo: assert property (p_solo) else $error("solo lost");
  a_win: assert property (p_win) else $error("window err");
endmodule
bind spreader_param_write_port spw_asserts i_chk (.*);
`default_nettype wire

// ---- testbench/testbench.sv ----
// Bench for the parameter memory write port
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic i_mclk = 0, i_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic i_dp_rd = 0, i_dp_bank = 0, go = 0, err;
  logic [2:0] i_dp_spreader = 0;
  logic [3:0] i_dp_word = 0;
  logic [7:0] fa = 0;
  logic [11:0] i_paddr = 0;
  logic [31:0] i_pwdata = 0, fd = 0, rd;
  wire o_pready, o_pslverr, o_fetch_lost, o_fetch_refused, i_fetch_wr;
  wire i_fetch_bank;
  wire [2:0] i_fetch_spreader;
  wire [3:0] i_fetch_word;
  wire [31:0] o_prdata, o_dp_rdata, i_fetch_data;
  int fails = 0, total_checks = 0, cyc = 0;
  spreader_param_write_port i_dut (.*);
  fetch_model i_fm (.i_mclk, .i_go(go), .i_addr(fa), .i_data(fd),
    .o_wr(i_fetch_wr), .o_data(i_fetch_data),
    .o_addr({i_fetch_bank, i_fetch_spreader, i_fetch_word}));
  initial forever #5 i_mclk = ~i_mclk;
  always @(posedge i_mclk) if (++cyc == 3000) begin
    fails++;
    print_verdict;
  end
  task chk(input logic [31:0] s, e, input string n);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  task apb(input logic w, f, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_mclk);
    i_psel <= 1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    go <= f;
    @(posedge i_mclk);
    i_penable <= 1;
    go <= 0;
    do @(posedge i_mclk); while (!o_pready && ++n < 50);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 0;
    i_penable <= 0;
  endtask
  task dp(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_mclk);
    i_dp_rd <= 1;
    {i_dp_bank, i_dp_spreader, i_dp_word} <= a;
    @(posedge i_mclk);
    i_dp_rd <= 0;
    @(negedge i_mclk);
    chk(o_dp_rdata, e, "dp data");
  endtask
  task fetch(input logic [7:0] a, input logic [31:0] d, input logic r);
    @(posedge i_mclk);
    fa <= a;
    fd <= d;
    go <= 1;
    @(posedge i_mclk);
    go <= 0;
    @(posedge i_mclk);
    @(negedge i_mclk);
    chk(o_fetch_refused, r, "refused");
  endtask
  task t_regs;
    apb(0, 0, 12'h000, 0);
    chk(rd, 32'h0, "ctrl");
    apb(0, 0, 12'h004, 0);
    chk(rd, 32'h0000_000f, "mask");
    apb(1, 0, 12'h00c, 32'h5);
    chk(err, 1, "unmapped");
    $display("regs done");
  endtask
  task t_fetch;
    for (int i = 0; i < 4; i++) begin
      fetch({4'h1, i[3:0]}, 32'h100 + i, 0);
      dp({4'h1, i[3:0]}, 32'h100 + i);
    end
    fetch(8'h14, 32'h55, 1);
    apb(1, 0, 12'h000, 32'h0000_0200);
    fetch(8'h10, 32'h66, 1);
    dp(8'h10, 32'h100);
    apb(1, 0, 12'h000, 0);
    $display("fetch done");
  endtask
  task t_corr;
    fa <= 8'h90;
    fd <= 32'h1234;
    apb(1, 1, 12'h644, 32'h77);
    dp(8'h90, 32'h1234);
    dp(8'h91, 32'h77);
    apb(0, 0, 12'h008, 0);
    chk(rd, 32'h0001_0000, "defer count");
    $display("corrected done");
  endtask
  task t_legacy;
    apb(1, 0, 12'h008, 0);
    apb(1, 0, 12'h000, 32'h1);
    fa <= 8'h90;
    fd <= 32'hbad;
    apb(1, 1, 12'h648, 32'h88);
    @(negedge i_mclk);
    chk(o_fetch_lost, 1, "lost");
    dp(8'h90, 32'h1234);
    dp(8'h92, 32'h88);
    apb(0, 0, 12'h008, 0);
    chk(rd, 32'h1, "lost count");
    fd <= 32'h1234;
    apb(1, 1, 12'h648, 32'h99);
    dp(8'h90, 32'h1234);
    $display("legacy done");
  endtask
  task print_verdict;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge i_mclk);
    i_rst <= 0;
    t_regs;
    t_fetch;
    t_corr;
    t_legacy;
    print_verdict;
  end
endmodule
`default_nettype wire
